// ===== logic/mtcm_top.sv
// Purpose: tooth wheel event counter, multiplied clock and one-shot pulse timer
// Assumes: tooth input synchronous to CLK; register reads answer one cycle later
// Notes:   only clock buses 0 (prescaler) and 5 are modelled
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module mtcm_top
  import mtcm_pkg::*;
(
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              RST_N,
  // tooth wheel pin
  input  wire logic              TOOTH_PULSE_INPUT,
  // register port
  input  wire logic [7:0]        ADDR,
  input  wire logic [31:0]       WDATA,
  input  wire logic              WE,
  input  wire logic              RE,
  output logic      [31:0]       RDATA,
  // outputs
  output logic      [NCH-1:0]    ONESHOT_OUTPUT,
  output logic                   MULT_CMP_IRQ
);
  typedef struct packed {
    logic [15:0]      presc;
    logic [15:0]      pre_cnt;
    logic [7:0]       cap_evt;
    logic [15:0]      cap_edge;
    logic [7:0]       cbsel;
    logic [7:0]       mt_ctl;
    logic [7:0]       mio_ctl;
    logic [15:0]      base_ratio;
    logic [15:0]      gap_ratio;
    logic [15:0]      ien;
    logic [7:0]       irt;
    logic             cmp_flag;
    logic [15:0]      tooth;
    logic [15:0]      cyc_cmp;
    logic [15:0]      sw_cmp;
    logic [19:0]      clim;
    logic [19:0]      ccnt;
    logic [19:0]      mcnt;
    logic [19:0]      mcmp;
    logic [15:0]      evcnt;
    logic [15:0]      refcnt;
    logic [31:0]      ivl;
    logic [31:0]      period;
    logic [31:0]      acc;
    logic [15:0]      pt_ctl;
    logic [15:0]      pt_io;
    logic [15:0]      dc_ctl;
    logic [15:0]      start;
    logic [31:0]      upcnt;
    logic [NCH-1:0][31:0] ocmp;
    logic [NCH-1:0][31:0] wcnt;
    logic [NCH-1:0]   run;
    logic [NCH-1:0]   out;
    logic [7:0]       seq_ctl;
    logic [7:0]       seq_en;
    logic [2:0][15:0] seq_cmp;
    logic [1:0]       seq_st;
    logic             pin_prev;
    logic [31:0]      rdata;
  } mtcm_state_t;

  mtcm_state_t s_ff;
  mtcm_state_t nxt_s;

  logic             presc_tick;
  logic             ext_evt;
  logic             mt_tick;
  logic [15:0]      ratio_act;
  logic [32:0]      acc_sum;
  logic             acc_step;
  logic             mult_pulse;
  logic             bus5;
  logic             tooth_clr;
  logic             mul_match;
  logic             up_tick;
  logic             dn_tick;
  logic [15:0]      tooth_inc;
  logic [NCH-1:0]   oc_match;
  logic [NCH-1:0]   dn_start;
  logic [2:0]       seq_hit;

  function automatic logic bus_pick(input logic [3:0] sel, input logic b0, input logic b5);
    bus_pick = (sel == BUS5) ? b5 : ((sel == BUS0) ? b0 : 1'b0);
  endfunction

  assign presc_tick = (s_ff.pre_cnt == s_ff.presc);
  // edge taken against last sample; pin is already synchronous
  assign ext_evt = s_ff.cap_evt[B_CAP_FWD] & s_ff.mio_ctl[B_EVT_EN]
                 & ((s_ff.cap_edge[B_EDGE_RISE] & TOOTH_PULSE_INPUT & ~s_ff.pin_prev)
                 |  (s_ff.cap_edge[B_EDGE_FALL] & ~TOOTH_PULSE_INPUT & s_ff.pin_prev));
  assign mt_tick   = (s_ff.mt_ctl[2:0] == MT_BUS0) & presc_tick;
  assign ratio_act = (s_ff.mt_ctl[B_AUTO_SW] && s_ff.tooth == s_ff.sw_cmp)
                   ? s_ff.gap_ratio : s_ff.base_ratio;
  assign acc_sum   = {1'b0, s_ff.acc} + {17'h0, ratio_act};
  // correction counter at its limit holds pulses back until a tooth arrives while the event counter is zero
  assign acc_step  = mt_tick & (s_ff.period != 32'h0) & (s_ff.ccnt < s_ff.clim);
  assign mult_pulse = acc_step & (acc_sum >= {1'b0, s_ff.period});
  assign bus5      = (s_ff.cbsel == CBS_MULT) & mult_pulse;
  assign tooth_clr = s_ff.mt_ctl[B_TOOTH_CLR] & (s_ff.tooth == s_ff.cyc_cmp);
  assign mul_match = mult_pulse & (s_ff.mcnt + 20'h1 == s_ff.mcmp);
  assign up_tick   = s_ff.start[B_SUB0_RUN] & bus_pick(s_ff.pt_ctl[3:0], presc_tick, bus5);
  assign dn_tick   = s_ff.start[B_SUB0_RUN] & bus_pick(s_ff.pt_ctl[7:4], presc_tick, bus5);
  assign tooth_inc = (tooth_clr ? 16'h0 : s_ff.tooth) + 16'h1;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      assign oc_match[gi] = up_tick & (s_ff.pt_io[2*gi+:2] != 2'h0)
                          & (s_ff.upcnt + 32'h1 == s_ff.ocmp[gi]);
      assign dn_start[gi] = oc_match[gi] & (s_ff.dc_ctl[4*gi+:4] == DC_ON_CMPA);
    end
    for (gi = 0; gi < 3; gi++) begin : g_seq
      assign seq_hit[gi] = s_ff.seq_ctl[B_SEQ_EN] & s_ff.seq_en[gi] & ext_evt
                         & (tooth_inc == s_ff.seq_cmp[gi]);
    end
  endgenerate

  always_comb begin
    nxt_s = s_ff;
    nxt_s.rdata = RST_WORD;
    nxt_s.pin_prev = TOOTH_PULSE_INPUT;
    nxt_s.pre_cnt = presc_tick ? 16'h0 : s_ff.pre_cnt + 16'h1;
    if (tooth_clr) begin
      nxt_s.tooth = 16'h0;
      nxt_s.seq_st = 2'h0;
    end
    if (ext_evt) begin
      nxt_s.tooth = tooth_inc;
    end
    if (|seq_hit && s_ff.seq_st != SEQ_LAST) begin
      nxt_s.seq_st = s_ff.seq_st + 2'h1;
    end
    if (s_ff.mt_ctl[B_EVCNT_CLR] && tooth_clr) begin
      nxt_s.evcnt = 16'h0;
    end
    if (ext_evt) begin
      nxt_s.evcnt = nxt_s.evcnt + 16'h1;
    end
    // interval measure feeds the evenly spread pulse train
    if (ext_evt) begin
      nxt_s.period = s_ff.ivl;
      nxt_s.ivl = 32'h0;
      nxt_s.acc = 32'h0;
    end else begin
      if (mt_tick && s_ff.ivl != 32'hffffffff) begin
        nxt_s.ivl = s_ff.ivl + 32'h1;
      end
      if (acc_step) begin
        nxt_s.acc = mult_pulse ? acc_sum[31:0] - s_ff.period : acc_sum[31:0];
      end
    end
    if (ext_evt && s_ff.evcnt == 16'h0 && s_ff.ccnt == s_ff.clim) begin
      nxt_s.ccnt = 20'h1;
    end else if (mult_pulse) begin
      nxt_s.ccnt = s_ff.ccnt + 20'h1;
    end
    if (mult_pulse && (s_ff.mio_ctl[B_REF_NOSTOP] || s_ff.refcnt != s_ff.evcnt)) begin
      nxt_s.refcnt = s_ff.refcnt + 16'h1;
    end
    if (mult_pulse) begin
      nxt_s.mcnt = s_ff.mcnt + 20'h1;
    end
    if (s_ff.pt_ctl[B_UP_CLR_EN] && tooth_clr) begin
      nxt_s.upcnt = 32'h0;
    end else if (up_tick) begin
      nxt_s.upcnt = s_ff.upcnt + 32'h1;
    end
    for (int i = 0; i < NCH; i++) begin
      if (dn_start[i]) begin
        nxt_s.run[i] = 1'b1;
        nxt_s.out[i] = 1'b1;
      end else if (s_ff.run[i] && dn_tick) begin
        nxt_s.wcnt[i] = s_ff.wcnt[i] - 32'h1;
        if (s_ff.wcnt[i] == 32'h0) begin
          nxt_s.run[i] = 1'b0;
          nxt_s.out[i] = 1'b0;
        end
      end
    end
    if (WE) begin
      unique case (ADDR)
        A_PRESC:   nxt_s.presc = WDATA[15:0];
        A_CAPEVT:  nxt_s.cap_evt = WDATA[7:0];
        A_CAPEDGE: nxt_s.cap_edge = WDATA[15:0];
        A_CBSEL:   nxt_s.cbsel = WDATA[7:0];
        A_MTCTL:   nxt_s.mt_ctl = WDATA[7:0];
        A_MIOCTL:  nxt_s.mio_ctl = WDATA[7:0];
        A_BASE:    nxt_s.base_ratio = WDATA[15:0];
        A_GAP:     nxt_s.gap_ratio = WDATA[15:0];
        A_IEN:     nxt_s.ien = WDATA[15:0];
        A_IRT:     nxt_s.irt = WDATA[7:0];
        A_CYCCMP:  nxt_s.cyc_cmp = WDATA[15:0];
        A_SWCMP:   nxt_s.sw_cmp = WDATA[15:0];
        A_CLIM:    nxt_s.clim = WDATA[31:FRAC];
        A_CCNT:    nxt_s.ccnt = WDATA[31:FRAC];
        A_MCNT:    nxt_s.mcnt = WDATA[31:FRAC];
        A_MCMP:    nxt_s.mcmp = WDATA[31:FRAC];
        A_EVCNT:   nxt_s.evcnt = WDATA[15:0];
        A_PTCTL:   nxt_s.pt_ctl = WDATA[15:0];
        A_PTIO:    nxt_s.pt_io = WDATA[15:0];
        A_DCCTL:   nxt_s.dc_ctl = WDATA[15:0];
        A_START:   nxt_s.start = WDATA[15:0];
        A_SEQCTL:  nxt_s.seq_ctl = WDATA[7:0];
        A_SEQEN:   nxt_s.seq_en = WDATA[7:0];
        default: begin
          for (int i = 0; i < NCH; i++) begin
            if (ADDR == A_OCMP0 + 8'(4*i)) nxt_s.ocmp[i] = WDATA;
            if (ADDR == A_WCNT0 + 8'(4*i)) nxt_s.wcnt[i] = WDATA;
          end
          for (int i = 0; i < 3; i++) begin
            if (ADDR == A_SEQCMP0 + 8'(4*i)) nxt_s.seq_cmp[i] = WDATA[15:0];
          end
        end
      endcase
    end
    // a match in the clearing cycle keeps the flag set
    if (WE && ADDR == A_STAT && WDATA[B_CMP_FLAG]) begin
      nxt_s.cmp_flag = 1'b0;
    end
    if (mul_match) begin
      nxt_s.cmp_flag = 1'b1;
    end
    if (RE) begin
      unique case (ADDR)
        A_PRESC:   nxt_s.rdata = {16'h0, s_ff.presc};
        A_CAPEVT:  nxt_s.rdata = {24'h0, s_ff.cap_evt};
        A_CAPEDGE: nxt_s.rdata = {16'h0, s_ff.cap_edge};
        A_CBSEL:   nxt_s.rdata = {24'h0, s_ff.cbsel};
        A_MTCTL:   nxt_s.rdata = {24'h0, s_ff.mt_ctl};
        A_MIOCTL:  nxt_s.rdata = {24'h0, s_ff.mio_ctl};
        A_BASE:    nxt_s.rdata = {16'h0, s_ff.base_ratio};
        A_GAP:     nxt_s.rdata = {16'h0, s_ff.gap_ratio};
        A_IEN:     nxt_s.rdata = {16'h0, s_ff.ien};
        A_IRT:     nxt_s.rdata = {24'h0, s_ff.irt};
        A_STAT:    nxt_s.rdata = {28'h0, s_ff.cmp_flag, 3'h0};
        A_TOOTH:   nxt_s.rdata = {16'h0, s_ff.tooth};
        A_CYCCMP:  nxt_s.rdata = {16'h0, s_ff.cyc_cmp};
        A_SWCMP:   nxt_s.rdata = {16'h0, s_ff.sw_cmp};
        A_CLIM:    nxt_s.rdata = {s_ff.clim, 12'h0};
        A_CCNT:    nxt_s.rdata = {s_ff.ccnt, 12'h0};
        A_MCNT:    nxt_s.rdata = {s_ff.mcnt, 12'h0};
        A_MCMP:    nxt_s.rdata = {s_ff.mcmp, 12'h0};
        A_EVCNT:   nxt_s.rdata = {16'h0, s_ff.evcnt};
        A_REFCNT:  nxt_s.rdata = {16'h0, s_ff.refcnt};
        A_PTCTL:   nxt_s.rdata = {16'h0, s_ff.pt_ctl};
        A_PTIO:    nxt_s.rdata = {16'h0, s_ff.pt_io};
        A_DCCTL:   nxt_s.rdata = {16'h0, s_ff.dc_ctl};
        A_START:   nxt_s.rdata = {16'h0, s_ff.start};
        A_UPCNT:   nxt_s.rdata = s_ff.upcnt;
        A_SEQCTL:  nxt_s.rdata = {24'h0, s_ff.seq_ctl};
        A_SEQEN:   nxt_s.rdata = {24'h0, s_ff.seq_en};
        A_SEQST:   nxt_s.rdata = {30'h0, s_ff.seq_st};
        default: begin
          for (int i = 0; i < NCH; i++) begin
            if (ADDR == A_OCMP0 + 8'(4*i)) nxt_s.rdata = s_ff.ocmp[i];
            if (ADDR == A_WCNT0 + 8'(4*i)) nxt_s.rdata = s_ff.wcnt[i];
          end
          for (int i = 0; i < 3; i++) begin
            if (ADDR == A_SEQCMP0 + 8'(4*i)) nxt_s.rdata = {16'h0, s_ff.seq_cmp[i]};
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign RDATA = s_ff.rdata;
  assign ONESHOT_OUTPUT = s_ff.out;
  assign MULT_CMP_IRQ = s_ff.cmp_flag & s_ff.ien[B_CMP_FLAG] & ~s_ff.irt[B_ROUTE_OFF];

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_tooth_step: assert property (ext_evt && !tooth_clr |=> s_ff.tooth == $past(s_ff.tooth) + 16'h1)
    else $error("tooth counter did not step on event");
  a_tooth_clear: assert property (tooth_clr && !ext_evt |=> s_ff.tooth == 16'h0)
    else $error("tooth counter not cleared at cycle match");
  a_gap_ratio: assert property (s_ff.mt_ctl[B_AUTO_SW] && s_ff.tooth == s_ff.sw_cmp
    |-> ratio_act == s_ff.gap_ratio)
    else $error("gap ratio not applied");
  a_flag_set: assert property (mul_match |=> s_ff.cmp_flag ##0 MULT_CMP_IRQ == (s_ff.ien[3] & ~s_ff.irt[0]))
    else $error("compare flag or request wrong after match");
  a_flag_clear: assert property (WE && ADDR == A_STAT && WDATA[3] && !mul_match |=> !s_ff.cmp_flag)
    else $error("compare flag not dropped");
  a_presc_gap: assert property (presc_tick && s_ff.presc != 16'h0 && !(WE && ADDR == A_PRESC) |=> !presc_tick)
    else $error("prescaler ticked too early");
  a_shot_rise: assert property (dn_start[0] |=> ONESHOT_OUTPUT[0] && s_ff.run[0])
    else $error("one-shot did not rise on start");
  a_shot_fall: assert property (s_ff.run[1] && dn_tick && s_ff.wcnt[1] == 32'h0 && !dn_start[1]
    |=> !ONESHOT_OUTPUT[1])
    else $error("one-shot did not fall on underflow");
  a_seq_step: assert property (|seq_hit && !tooth_clr && s_ff.seq_st != 2'h3
    |=> s_ff.seq_st == $past(s_ff.seq_st) + 2'h1)
    else $error("sequencer status did not step");
  a_read_late: assert property (RE && ADDR == A_TOOTH |=> RDATA[15:0] == $past(s_ff.tooth))
    else $error("read data not one cycle later");
  // counter chain behind the multiplied clock, then event gating and clears at the cycle match
  a_gap_accum: assert property (s_ff.mt_ctl[B_AUTO_SW] && s_ff.tooth == s_ff.sw_cmp
    && acc_step && !mult_pulse && !ext_evt |=> s_ff.acc == $past(s_ff.acc) + $past(s_ff.gap_ratio))
    else $error("gap ratio not added to accumulator");
  a_ccnt_reload: assert property (ext_evt && s_ff.evcnt == 16'h0 && s_ff.ccnt == s_ff.clim
    && !(WE && ADDR == A_CCNT) |=> s_ff.ccnt == 20'h1)
    else $error("correction counter not reloaded to one");
  a_ccnt_hold: assert property (s_ff.ccnt >= s_ff.clim && !ext_evt && !(WE && ADDR == A_CCNT)
    |=> $stable(s_ff.ccnt))
    else $error("correction counter moved past its limit");
  a_mcnt_step: assert property (mult_pulse && !(WE && ADDR == A_MCNT)
    |=> s_ff.mcnt == $past(s_ff.mcnt) + 20'h1)
    else $error("multiplied counter did not step");
  a_ref_nostop: assert property (mult_pulse && s_ff.mio_ctl[B_REF_NOSTOP]
    |=> s_ff.refcnt == $past(s_ff.refcnt) + 16'h1)
    else $error("reference counter stopped");
  a_event_gate: assert property (!s_ff.mio_ctl[B_EVT_EN] && !tooth_clr |=> $stable(s_ff.tooth))
    else $error("tooth counted with events disabled");
  a_evcnt_clear: assert property (s_ff.mt_ctl[B_EVCNT_CLR] && tooth_clr && !ext_evt
    && !(WE && ADDR == A_EVCNT) |=> s_ff.evcnt == 16'h0)
    else $error("event counter not cleared");
  a_seq_clear: assert property (tooth_clr && !(|seq_hit) |=> s_ff.seq_st == 2'h0)
    else $error("sequencer status not cleared with tooth");
  // pulse timer subblock
  a_up_clear: assert property (s_ff.pt_ctl[B_UP_CLR_EN] && tooth_clr |=> s_ff.upcnt == 32'h0)
    else $error("up counter not cleared");
  a_up_step: assert property (up_tick && !(s_ff.pt_ctl[B_UP_CLR_EN] && tooth_clr)
    |=> s_ff.upcnt == $past(s_ff.upcnt) + 32'h1)
    else $error("up counter did not step");
  a_up_source: assert property (s_ff.start[B_SUB0_RUN] && s_ff.pt_ctl[3:0] == BUS5
    && s_ff.cbsel == CBS_MULT |-> up_tick == mult_pulse)
    else $error("up counter not on multiplied clock");
  a_down_step: assert property (s_ff.run[2] && dn_tick && !dn_start[2]
    && !(WE && ADDR == A_WCNT0 + 8'h08) |=> s_ff.wcnt[2] == $past(s_ff.wcnt[2]) - 32'h1)
    else $error("width counter did not count down");

  // main scenarios
  c_mult_pulse: cover property (ext_evt ##[1:200] mult_pulse);
  c_oneshot:    cover property (ONESHOT_OUTPUT[0] ##[1:200] !ONESHOT_OUTPUT[0]);
  c_seq_top:    cover property (s_ff.seq_st == 2'h3);
  c_irq:        cover property ($rose(MULT_CMP_IRQ));
  c_gap_used:   cover property (s_ff.mt_ctl[B_AUTO_SW] && s_ff.tooth == s_ff.sw_cmp && mult_pulse);
endmodule

// ===== logic/mtcm_pkg.sv
// Purpose: constants for the missing-tooth clock multiplier block
// Assumes: 32-bit register port, byte addresses, one word per register
// Notes:   fixed-point counters keep 12 fraction bits in their register image
package mtcm_pkg;
  localparam int NCH  = 4;
  localparam int FRAC = 12;
  // register byte offsets
  localparam logic [7:0] A_PRESC   = 8'h00;
  localparam logic [7:0] A_CAPEVT  = 8'h04;
  localparam logic [7:0] A_CAPEDGE = 8'h08;
  localparam logic [7:0] A_CBSEL   = 8'h0c;
  localparam logic [7:0] A_MTCTL   = 8'h10;
  localparam logic [7:0] A_MIOCTL  = 8'h14;
  localparam logic [7:0] A_BASE    = 8'h18;
  localparam logic [7:0] A_GAP     = 8'h1c;
  localparam logic [7:0] A_IEN     = 8'h20;
  localparam logic [7:0] A_IRT     = 8'h24;
  localparam logic [7:0] A_STAT    = 8'h28;
  localparam logic [7:0] A_TOOTH   = 8'h2c;
  localparam logic [7:0] A_CYCCMP  = 8'h30;
  localparam logic [7:0] A_SWCMP   = 8'h34;
  localparam logic [7:0] A_CLIM    = 8'h38;
  localparam logic [7:0] A_CCNT    = 8'h3c;
  localparam logic [7:0] A_MCNT    = 8'h40;
  localparam logic [7:0] A_MCMP    = 8'h44;
  localparam logic [7:0] A_EVCNT   = 8'h48;
  localparam logic [7:0] A_PTCTL   = 8'h4c;
  localparam logic [7:0] A_PTIO    = 8'h50;
  localparam logic [7:0] A_DCCTL   = 8'h54;
  localparam logic [7:0] A_START   = 8'h58;
  localparam logic [7:0] A_UPCNT   = 8'h5c;
  localparam logic [7:0] A_OCMP0   = 8'h60;
  localparam logic [7:0] A_WCNT0   = 8'h70;
  localparam logic [7:0] A_SEQCTL  = 8'h80;
  localparam logic [7:0] A_SEQEN   = 8'h84;
  localparam logic [7:0] A_SEQCMP0 = 8'h88;
  localparam logic [7:0] A_SEQST   = 8'h94;
  localparam logic [7:0] A_REFCNT  = 8'h98;
  // field positions and codes
  localparam int B_CAP_FWD   = 3;
  localparam int B_EDGE_RISE = 0;
  localparam int B_EDGE_FALL = 1;
  localparam int B_AUTO_SW   = 7;
  localparam int B_EVCNT_CLR = 6;
  localparam int B_TOOTH_CLR = 5;
  localparam int B_EVT_EN    = 0;
  localparam int B_REF_NOSTOP = 5;
  localparam int B_CMP_FLAG  = 3;
  localparam int B_ROUTE_OFF = 0;
  localparam int B_UP_CLR_EN = 12;
  localparam int B_SEQ_EN    = 0;
  localparam int B_SUB0_RUN  = 0;
  localparam logic [7:0] CBS_MULT   = 8'h04;
  localparam logic [2:0] MT_BUS0    = 3'h0;
  localparam logic [3:0] BUS0       = 4'h0;
  localparam logic [3:0] BUS5       = 4'h5;
  localparam logic [3:0] DC_ON_CMPA = 4'h2;
  localparam logic [1:0] SEQ_LAST   = 2'h3;
  localparam logic [31:0] RST_WORD  = 32'h0;
endpackage

// ===== verification/mtcm_wheel_model.sv
// Purpose: toothed wheel pulse source facing the tooth pulse input
// Assumes: pulses line up with the bench clock; period of at least 4 cycles
// Notes:   per_rev of 0 gives an unbroken wheel with no gap
`timescale 1ns/1ps
module mtcm_wheel_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // wheel shape
  input  wire logic        run,
  input  wire logic [15:0] period,
  input  wire logic [7:0]  per_rev,
  input  wire logic [3:0]  missing,
  // pin and tooth tally
  output logic             pin,
  output int unsigned      teeth
);
  logic [15:0] tick_ff;
  logic [7:0]  pos_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_ff <= 16'h0;
      pos_ff  <= 8'h0;
      pin     <= 1'b0;
      teeth   <= 0;
    end else if (!run) begin
      // the sensor line rests low while the wheel stands still
      pin <= 1'b0;
    end else if (tick_ff == period - 16'h1) begin
      tick_ff <= 16'h0;
      pos_ff  <= (pos_ff == per_rev + {4'h0, missing} - 8'h1) ? 8'h0 : pos_ff + 8'h1;
      // positions from per_rev onward are the gap: no pulse there
      if (per_rev == 8'h0 || pos_ff < per_rev) begin
        pin   <= 1'b1;
        teeth <= teeth + 1;
      end
    end else begin
      tick_ff <= tick_ff + 16'h1;
      if (tick_ff == period / 2) begin
        pin <= 1'b0;
      end
    end
  end
endmodule

// ===== verification/tb_missing_tooth_clock_multiplier.sv
// Purpose: register-level tests of the tooth counter, sequencer and one-shots
// Assumes: register port answers reads one cycle after the strobe
// Notes:   no interrupt controller here; the compare request is watched directly
`timescale 1ns/1ps
module tb_missing_tooth_clock_multiplier;
  import mtcm_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, we = 1'b0, re = 1'b0, run = 1'b0;
  logic [7:0]  addr = 8'h0, per_rev = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [15:0] period = 16'h28;
  logic [3:0]  missing = 4'h0, osh, osh_q = 4'h0, rose = 4'h0, fell = 4'h0;
  logic        irq, tooth;
  int unsigned teeth;
  int          bad_count = 0, comparisons = 0;
  logic [7:0]  cfg_a [22];
  logic [31:0] cfg_d [22];

  mtcm_top uut (.CLK(clk), .RST_N(rst_n), .TOOTH_PULSE_INPUT(tooth), .ADDR(addr), .WDATA(wdata),
    .WE(we), .RE(re), .RDATA(rdata), .ONESHOT_OUTPUT(osh), .MULT_CMP_IRQ(irq));
  mtcm_wheel_model wheel (.clk(clk), .rst_n(rst_n), .run(run), .period(period), .per_rev(per_rev),
    .missing(missing), .pin(tooth), .teeth(teeth));

  always #10 clk = ~clk;
  always @(posedge clk) begin
    osh_q <= osh;
    rose  <= rose | (osh & ~osh_q);
    fell  <= fell | (~osh & osh_q);
  end

  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    we    <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    re   <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    rd(a, d);
    chk(what, exp, d);
  endtask

  // lets the wheel turn until n more teeth have been sent, then stops it
  task automatic spin(input int n);
    int target;
    target = teeth + n;
    run <= 1'b1;
    for (int i = 0; i < 20000 && teeth < target; i++) begin
      @(posedge clk);
      #1;
    end
    run <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end

  initial begin
    cfg_a = '{A_PRESC, A_CAPEVT, A_CAPEDGE, A_CBSEL, A_MTCTL, A_MIOCTL, A_BASE, A_GAP, A_IEN, A_IRT,
      A_CYCCMP, A_SWCMP, A_CLIM, A_MCMP, A_PTCTL, A_PTIO, A_DCCTL, A_SEQCTL, A_SEQEN, A_SEQCMP0,
      A_SEQCMP0 + 8'h04, A_SEQCMP0 + 8'h08};
    // gap ratio 12 is base 4 times two missing teeth plus one
    cfg_d = '{32'h9, 32'h8, 32'h1, 32'h4, 32'h0, 32'h21, 32'h4, 32'hc, 32'h8, 32'h0,
      32'ha, 32'h1, 32'h30000, 32'h6000, 32'h1055, 32'hff, 32'h2222, 32'h1, 32'h7, 32'h3,
      32'h6, 32'h8};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rchk("tooth after reset", A_TOOTH, 32'h0);
    rchk("status after reset", A_SEQST, 32'h0);
    rchk("reference after reset", A_REFCNT, 32'h0);
    rchk("unmapped read", 8'hfc, 32'h0);
    wr(A_TOOTH, 32'h55);
    rchk("read-only tooth", A_TOOTH, 32'h0);
    foreach (cfg_a[i]) wr(cfg_a[i], cfg_d[i]);
    foreach (cfg_a[i]) rchk("config readback", cfg_a[i], cfg_d[i]);
    spin(2);
    rchk("tooth count 2", A_TOOTH, 32'h2);
    rchk("status before first match", A_SEQST, 32'h0);
    spin(1);
    rchk("tooth count 3", A_TOOTH, 32'h3);
    rchk("status first match", A_SEQST, 32'h1);
    spin(3);
    rchk("status second match", A_SEQST, 32'h2);
    spin(2);
    rchk("tooth count 8", A_TOOTH, 32'h8);
    rchk("status third match", A_SEQST, 32'h3);
    // stopping the wheel drops the pin, which is the falling edge counted here
    wr(A_CAPEDGE, 32'h2);
    spin(1);
    rchk("falling edge count", A_TOOTH, 32'h9);
    wr(A_CAPEDGE, 32'h1);
    wr(A_MTCTL, 32'he0);
    spin(1);
    rchk("tooth cleared at cycle compare", A_TOOTH, 32'h0);
    rchk("status cleared with tooth", A_SEQST, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(A_OCMP0 + 8'(4 * i), 32'h2 << i);
      wr(A_WCNT0 + 8'(4 * i), 32'h3);
    end
    wr(A_CCNT, 32'h30000);
    wr(A_MCNT, 32'h0);
    wr(A_START, 32'h1);
    // the first spins already set the flag, as mcnt reaches mcmp 6 before ccnt stops at clim 48; clear it so the wait below sees a fresh match
    wr(A_STAT, 32'h8);
    settle(1);
    chk("request cleared before restart", 32'(irq), 32'h0);
    period  <= 16'hc8;
    per_rev <= 8'h0a;
    missing <= 4'h2;
    run     <= 1'b1;
    for (int i = 0; i < 20000 && irq !== 1'b1; i++) settle(1);
    chk("compare request", 32'(irq), 32'h1);
    rd(A_STAT, d);
    chk("compare flag", 32'(d[B_CMP_FLAG]), 32'h1);
    wr(A_IRT, 32'h1);
    settle(2);
    chk("request while routed off", 32'(irq), 32'h0);
    wr(A_IRT, 32'h0);
    wr(A_STAT, 32'h8);
    settle(2);
    chk("request after flag clear", 32'(irq), 32'h0);
    rd(A_STAT, d);
    chk("flag after clear", 32'(d[B_CMP_FLAG]), 32'h0);
    for (int i = 0; i < 20000 && (rose !== 4'hf || fell !== 4'hf); i++) settle(1);
    chk("one-shot rises", 32'(rose), 32'hf);
    chk("one-shot falls", 32'(fell), 32'hf);
    run <= 1'b0;
    report_and_stop();
  end
endmodule
